// ---- sdc_clkgen_model.sv ----
// External reference source model: periodic or single-pulse reference.
// Assumes the same ref_clk as the block; phase detector is idealised.
module sdc_clkgen_model #(
    parameter int MF_CYC = 32,
    parameter int DIV = 1,
    parameter logic [7:0] ALIGN_CODE = 8'h23
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic periodic,
    input wire logic fire,
    input wire logic [7:0] coarse,
    // Reference outputs
    output logic sysref_in,
    output logic sysref_phase_aligned,
    output logic [15:0] edge_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ph_q;
    logic [2:0] pl_q;
    logic nx;
    // multiframe-rate clock or one long pulse
    assign nx = periodic ? (ph_q < 16'(MF_CYC * DIV / 2)) : (pl_q != 3'h0);
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ph_q <= 16'h0000;
            pl_q <= 3'h0;
            sysref_in <= 1'b0;
            edge_cnt <= 16'h0000;
        end
        else
        begin
            ph_q <= (ph_q == 16'(MF_CYC * DIV - 1)) ? 16'h0000 : ph_q + 16'h0001;
            pl_q <= fire ? 3'h6 : (pl_q != 3'h0) ? pl_q - 3'h1 : 3'h0;
            sysref_in <= nx;
            // edges held long enough for a deterministic capture
            if (nx && !sysref_in)
                edge_cnt <= edge_cnt + 16'h0001;
        end
    end
    // Detector sees alignment once the shifted clock reaches the reference phase
    assign sysref_phase_aligned = (coarse >= ALIGN_CODE);
endmodule // sdc_clkgen_model

// ---- sdc_pkg.sv ----
// Constants shared by the sampling clock and delay control block.
// Assumes a 32-bit classic Wishbone register bus and a 100 MHz ref_clk.
package sdc_pkg;

    // Register byte offsets
    localparam logic [7:0] SDC_OFF_CTRL = 8'h00;
    localparam logic [7:0] SDC_OFF_COARSE = 8'h04;
    localparam logic [7:0] SDC_OFF_FINE = 8'h08;
    localparam logic [7:0] SDC_OFF_STATUS = 8'h0c;
    localparam logic [7:0] SDC_OFF_SREF_CNT = 8'h10;

    // Control register fields
    localparam int SDC_CTRL_TS_EN = 0;
    localparam int SDC_CTRL_INV = 1;
    localparam int SDC_CTRL_RAMP_EN = 2;
    localparam int SDC_CTRL_RAMP_FAST = 3;
    localparam int SDC_CTRL_SINGLE = 4;
    localparam int SDC_CTRL_CAL_EN = 5;
    localparam int SDC_CTRL_W = 6;

    // Status register fields
    localparam int SDC_ST_COARSE_LSB = 0;
    localparam int SDC_ST_BUSY = 8;
    localparam int SDC_ST_CAL_DONE = 9;
    localparam int SDC_ST_SREF_SEEN = 10;

    // Reset values
    localparam logic [SDC_CTRL_W-1:0] SDC_CTRL_RST = 6'h00;
    localparam logic [7:0] SDC_DELAY_RST = 8'h00;

    // Delay code width: 256 settings each for coarse and fine
    localparam int SDC_DLY_W = 8;
    localparam int SDC_SAMPLE_W = 8;

    // Ramp timing: slow is 1 step per 256 cycles, fast is 4 steps per 384 cycles
    localparam int SDC_RAMP_SLOW_CYC = 256;
    localparam int SDC_RAMP_FAST_CYC = 384;
    localparam logic [8:0] SDC_RAMP_SLOW_LAST = 9'(SDC_RAMP_SLOW_CYC - 1);
    localparam logic [8:0] SDC_RAMP_FAST_LAST = 9'(SDC_RAMP_FAST_CYC - 1);
    localparam logic [7:0] SDC_RAMP_SLOW_STEP = 8'h01;
    localparam logic [7:0] SDC_RAMP_FAST_STEP = 8'h04;

    // Trigger synchroniser depth, matched by the data pipeline
    localparam int SDC_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SDC_CAL_IDLE,
        SDC_CAL_SEARCH,
        SDC_CAL_SETTLE,
        SDC_CAL_DONE
    } sdc_cal_e;

endpackage

// ---- sdc_ramp.sv ----
// Coarse delay ramp: walks the active coarse code toward a target.
// Assumes load is a one-cycle pulse on each new target write.
module sdc_ramp
    import sdc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic load,
    input wire logic [SDC_DLY_W-1:0] target,
    input wire logic ramp_en,
    input wire logic ramp_fast,
    // Result
    output logic [SDC_DLY_W-1:0] active_q,
    output logic busy_q
);

    logic [SDC_DLY_W-1:0] target_q;
    logic [8:0] tick_q;
    logic [SDC_DLY_W-1:0] diff;
    logic [SDC_DLY_W-1:0] step;
    logic up;
    logic tick_done;

    assign up = target_q > active_q;
    assign diff = up ? target_q - active_q : active_q - target_q;
    assign tick_done = tick_q == (ramp_fast ? SDC_RAMP_FAST_LAST : SDC_RAMP_SLOW_LAST);
    // No overshoot: last step is clipped to the remaining distance
    assign step = ramp_fast ? ((diff < SDC_RAMP_FAST_STEP) ? diff : SDC_RAMP_FAST_STEP)
                            : SDC_RAMP_SLOW_STEP;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            target_q <= SDC_DELAY_RST;
            active_q <= SDC_DELAY_RST;
            busy_q <= 1'b0;
            tick_q <= 9'h000;
        end
        else if (load && !ramp_en)
        begin
            target_q <= target;
            active_q <= target;
            busy_q <= 1'b0;
            tick_q <= 9'h000;
        end
        else if (load)
        begin
            target_q <= target;
            busy_q <= target != active_q;
            tick_q <= 9'h000;
        end
        else if (busy_q)
        begin
            if (tick_done)
            begin
                tick_q <= 9'h000;
                active_q <= up ? active_q + step : active_q - step;
                busy_q <= diff != step;
            end
            else
            begin
                tick_q <= tick_q + 9'h001;
            end
        end
    end

endmodule // sdc_ramp

// ---- sdc_top.sv ----
// Sampling clock and aperture delay control with timestamp marking.
// Assumes all pins, including the trigger, are sampled on ref_clk; the
// analog delay line and converter cores sit outside and follow the codes.

// Summary of operation
// - Timestamp ignored unless enable bit set
// - Enabled timestamp replaces sample LSB
// - Asynchronous trigger sampled alongside the data
// - Dual mode: one sample per rising edge
// - Single mode: rising and falling edges sampled
// - Device clock drives sampling and logic
// - SYSREF accepted as pulse or periodic
// - SYSREF captured on deterministic clock edge
// - Invert bit delays sampling half period
// - Coarse and fine give 256 settings
// - Invert, coarse, fine add independently
// - Delay shifts every internal clock equally
// - Delays writable during normal operation
// - Slow 1/256 or fast 4/384 ramp
// - Coarse write restarts ramp when enabled
// - Calibration moves sampling, not SYSREF
// - Calibration done flag for software polling
module sdc_top
    import sdc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter samples
    input wire logic conv_valid,
    input wire logic [SDC_SAMPLE_W-1:0] conv_rise_a,
    input wire logic [SDC_SAMPLE_W-1:0] conv_rise_b,
    input wire logic [SDC_SAMPLE_W-1:0] conv_fall,
    // Trigger and reference
    input wire logic trigger_marker_input,
    input wire logic sysref_in,
    input wire logic sysref_phase_aligned,
    // Output samples
    output logic out_valid,
    output logic [SDC_SAMPLE_W-1:0] out_sample_a,
    output logic [SDC_SAMPLE_W-1:0] out_sample_b,
    // Delay line codes
    output logic clock_invert_delay,
    output logic [SDC_DLY_W-1:0] coarse_aperture_delay,
    output logic [SDC_DLY_W-1:0] fine_aperture_delay,
    // Reference capture
    output logic sysref_capture,
    output logic sysref_cal_done
);

    // Byte-lane merge of a register write
    function automatic logic [31:0] sdc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Stamp the trigger into the sample LSB when enabled
    function automatic logic [SDC_SAMPLE_W-1:0] sdc_stamp(input logic [SDC_SAMPLE_W-1:0] s,
                                                          input logic en,
                                                          input logic trig);
        return en ? {s[SDC_SAMPLE_W-1:1], trig} : s;
    endfunction

    logic [SDC_CTRL_W-1:0] ctrl_q;
    logic [SDC_DLY_W-1:0] coarse_tgt_q;
    logic [SDC_DLY_W-1:0] fine_q;
    logic [15:0] sref_cnt_q;
    logic sref_seen_q;
    logic cal_done_q;
    sdc_cal_e cal_state_q;

    logic req;
    logic wr;
    logic rd;
    logic [31:0] wmerge;
    logic [31:0] rdata;
    logic coarse_load;
    logic [SDC_DLY_W-1:0] coarse_load_val;
    logic cal_step;
    logic [SDC_DLY_W-1:0] active_coarse;
    logic ramp_busy;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;

    // Bus answer: one cycle after the request, dropped the next cycle
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req;
        end
    end

    always_comb
    begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            SDC_OFF_CTRL:
            begin
                rdata[SDC_CTRL_W-1:0] = ctrl_q;
            end
            SDC_OFF_COARSE:
            begin
                rdata[SDC_DLY_W-1:0] = coarse_tgt_q;
            end
            SDC_OFF_FINE:
            begin
                rdata[SDC_DLY_W-1:0] = fine_q;
            end
            SDC_OFF_STATUS:
            begin
                rdata[SDC_ST_COARSE_LSB +: SDC_DLY_W] = active_coarse;
                rdata[SDC_ST_BUSY] = ramp_busy;
                rdata[SDC_ST_CAL_DONE] = cal_done_q;
                rdata[SDC_ST_SREF_SEEN] = sref_seen_q;
            end
            SDC_OFF_SREF_CNT:
            begin
                rdata[15:0] = sref_cnt_q;
            end
            default:
            begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (rd)
        begin
            wb_dat_o <= rdata;
        end
    end

    always_comb
    begin
        case (wb_adr_i)
            SDC_OFF_CTRL:
            begin
                wmerge = sdc_merge({26'h0, ctrl_q}, wb_dat_i, wb_sel_i);
            end
            SDC_OFF_COARSE:
            begin
                wmerge = sdc_merge({24'h0, coarse_tgt_q}, wb_dat_i, wb_sel_i);
            end
            SDC_OFF_FINE:
            begin
                wmerge = sdc_merge({24'h0, fine_q}, wb_dat_i, wb_sel_i);
            end
            default:
            begin
                wmerge = 32'h0000_0000;
            end
        endcase
    end

    // Control register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ctrl_q <= SDC_CTRL_RST;
        end
        else if (wr && wb_adr_i == SDC_OFF_CTRL)
        begin
            ctrl_q <= wmerge[SDC_CTRL_W-1:0];
        end
    end

    // delay codes writable at any time; the link may glitch meanwhile
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            fine_q <= SDC_DELAY_RST;
        end
        else if (wr && wb_adr_i == SDC_OFF_FINE)
        begin
            fine_q <= wmerge[SDC_DLY_W-1:0];
        end
    end

    // calibration steps the sampling delay, software writes lose to it
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            coarse_tgt_q <= SDC_DELAY_RST;
        end
        else if (cal_step)
        begin
            coarse_tgt_q <= coarse_tgt_q + 8'h01;
        end
        else if (wr && wb_adr_i == SDC_OFF_COARSE)
        begin
            coarse_tgt_q <= wmerge[SDC_DLY_W-1:0];
        end
    end

    assign coarse_load = cal_step || (wr && wb_adr_i == SDC_OFF_COARSE);
    assign coarse_load_val = cal_step ? coarse_tgt_q + 8'h01 : wmerge[SDC_DLY_W-1:0];

    // 8-bit code gives 256 coarse settings
    sdc_ramp u_ramp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(coarse_load),
        .target(coarse_load_val),
        .ramp_en(ctrl_q[SDC_CTRL_RAMP_EN]),
        .ramp_fast(ctrl_q[SDC_CTRL_RAMP_FAST]),
        .active_q(active_coarse),
        .busy_q(ramp_busy)
    );

    // three codes leave as separate fields, summed by the delay line
    // the shifted clock feeds the whole device, so capture moves too
    // invert bit selects the opposite clock phase
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            clock_invert_delay <= 1'b0;
            coarse_aperture_delay <= SDC_DELAY_RST;
            fine_aperture_delay <= SDC_DELAY_RST;
        end
        else
        begin
            clock_invert_delay <= ctrl_q[SDC_CTRL_INV];
            coarse_aperture_delay <= active_coarse;
            fine_aperture_delay <= fine_q;
        end
    end

    // two-stage synchroniser; data is delayed to match
    logic [SDC_SYNC_STAGES-1:0] trig_sync_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            trig_sync_q <= '0;
        end
        else
        begin
            trig_sync_q <= {trig_sync_q[SDC_SYNC_STAGES-2:0], trigger_marker_input};
        end
    end

    logic [SDC_SYNC_STAGES-1:0] vld_pipe_q;
    logic [SDC_SAMPLE_W-1:0] a_pipe_q [SDC_SYNC_STAGES];
    logic [SDC_SAMPLE_W-1:0] b_pipe_q [SDC_SYNC_STAGES];
    logic [SDC_SAMPLE_W-1:0] b_sel;

    // dual mode takes rising-edge samples of both inputs
    // single mode pairs rising and falling samples of one input
    assign b_sel = ctrl_q[SDC_CTRL_SINGLE] ? conv_fall : conv_rise_b;

    // samples and logic all run on the one device clock
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            vld_pipe_q <= '0;
            for (int i = 0; i < SDC_SYNC_STAGES; i++)
            begin
                a_pipe_q[i] <= '0;
                b_pipe_q[i] <= '0;
            end
        end
        else
        begin
            vld_pipe_q <= {vld_pipe_q[SDC_SYNC_STAGES-2:0], conv_valid};
            a_pipe_q[0] <= conv_rise_a;
            b_pipe_q[0] <= b_sel;
            for (int i = 1; i < SDC_SYNC_STAGES; i++)
            begin
                a_pipe_q[i] <= a_pipe_q[i-1];
                b_pipe_q[i] <= b_pipe_q[i-1];
            end
        end
    end

    // with the enable clear, data passes untouched
    // enabled marker replaces the LSB of each sample
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
            out_sample_a <= '0;
            out_sample_b <= '0;
        end
        else
        begin
            out_valid <= vld_pipe_q[SDC_SYNC_STAGES-1];
            out_sample_a <= sdc_stamp(a_pipe_q[SDC_SYNC_STAGES-1],
                                      ctrl_q[SDC_CTRL_TS_EN], trig_sync_q[SDC_SYNC_STAGES-1]);
            out_sample_b <= sdc_stamp(b_pipe_q[SDC_SYNC_STAGES-1],
                                      ctrl_q[SDC_CTRL_TS_EN], trig_sync_q[SDC_SYNC_STAGES-1]);
        end
    end

    // reference captured on one fixed rising edge, no free choice
    logic sref_q;
    logic sref_edge;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sref_q <= 1'b0;
        end
        else
        begin
            sref_q <= sysref_in;
        end
    end
    assign sref_edge = sysref_in && !sref_q;

    // a lone pulse or a periodic train both yield capture pulses
    // periodic rate is counted only, its ratio is the source's duty
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sysref_capture <= 1'b0;
            sref_seen_q <= 1'b0;
            sref_cnt_q <= 16'h0000;
        end
        else
        begin
            sysref_capture <= sref_edge;
            if (sref_edge)
            begin
                sref_seen_q <= 1'b1;
                sref_cnt_q <= sref_cnt_q + 16'h0001;
            end
        end
    end

    // Calibration: step coarse once per reference edge until aligned
    assign cal_step = cal_state_q == SDC_CAL_SEARCH && sref_edge && !sysref_phase_aligned
                      && !ramp_busy && coarse_tgt_q != 8'hff;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cal_state_q <= SDC_CAL_IDLE;
            cal_done_q <= 1'b0;
        end
        else if (!ctrl_q[SDC_CTRL_CAL_EN])
        begin
            cal_state_q <= SDC_CAL_IDLE;
            cal_done_q <= 1'b0;
        end
        else
        begin
            case (cal_state_q)
                SDC_CAL_IDLE:
                begin
                    cal_state_q <= SDC_CAL_SEARCH;
                end
                SDC_CAL_SEARCH:
                begin
                    if (sref_edge && (sysref_phase_aligned || coarse_tgt_q == 8'hff))
                    begin
                        cal_state_q <= SDC_CAL_SETTLE;
                    end
                end
                SDC_CAL_SETTLE:
                begin
                    if (!ramp_busy)
                    begin
                        cal_state_q <= SDC_CAL_DONE;
                    end
                end
                SDC_CAL_DONE:
                begin
                    // done holds until the enable is cleared
                    cal_done_q <= 1'b1;
                end
                default:
                begin
                    cal_state_q <= SDC_CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sysref_cal_done <= 1'b0;
        end
        else
        begin
            sysref_cal_done <= cal_done_q;
        end
    end

endmodule // sdc_top

// ---- sdc_top_chk.sv ----
// Port checker for the sampling clock and delay control block.
// Assumes it is bound to sdc_top and sees only that module's ports.
module sdc_top_chk
    import sdc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    // Samples
    input wire logic conv_valid,
    input wire logic [SDC_SAMPLE_W-1:0] conv_rise_a,
    input wire logic out_valid,
    input wire logic [SDC_SAMPLE_W-1:0] out_sample_a,
    // Reference and delay codes
    input wire logic sysref_in,
    input wire logic sysref_capture,
    input wire logic clock_invert_delay,
    input wire logic [SDC_DLY_W-1:0] fine_aperture_delay
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pipeline history counts only once it holds post-reset samples
    logic [2:0] up_q;
    always_ff @(posedge ref_clk)
        up_q <= !rst_n ? 3'h0 : up_q + 3'(up_q != 3'h7);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    valid_delay_a: assert property (up_q == 3'h7 |-> out_valid == $past(conv_valid, 3))
        else $error("sample strobe latency wrong");
    sample_data_a: assert property (
        up_q == 3'h7 |-> out_sample_a[7:1] == $past(conv_rise_a[7:1], 3))
        else $error("sample data upper bits wrong");
    capture_edge_a: assert property ($rose(sysref_in) |-> ##[1:3] sysref_capture)
        else $error("reference edge not captured");
    capture_cause_a: assert property (
        sysref_capture |-> $past(sysref_in) || $past(sysref_in, 2) || $past(sysref_in, 3))
        else $error("capture without reference");
    capture_pulse_a: assert property (sysref_capture |=> !sysref_capture)
        else $error("capture pulse too long");
    fine_write_a: assert property (!$stable(fine_aperture_delay) |->
        $past(wb_ack_o) && $past(wb_we_i) || $past(wb_ack_o, 2) && $past(wb_we_i, 2))
        else $error("fine code moved without write");
    invert_write_a: assert property (!$stable(clock_invert_delay) |->
        $past(wb_ack_o) && $past(wb_we_i) || $past(wb_ack_o, 2) && $past(wb_we_i, 2))
        else $error("invert moved without write");
endmodule // sdc_top_chk

bind sdc_top sdc_top_chk i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .conv_valid(conv_valid),
    .conv_rise_a(conv_rise_a), .out_valid(out_valid), .out_sample_a(out_sample_a),
    .sysref_in(sysref_in), .sysref_capture(sysref_capture),
    .clock_invert_delay(clock_invert_delay), .fine_aperture_delay(fine_aperture_delay));

// ---- tb.sv ----
// Self-checking bench for the sampling clock and delay control block.
// Assumes sdc_top, the reference model and the bound checker are compiled.
module tb
    import sdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00, rise_a = 8'h00, rise_b = 8'h00, fall = 8'h00;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rd, seed = 32'h8004;
    logic conv_valid = 1'b0, trig = 1'b0, periodic = 1'b0, fire = 1'b0;
    logic wb_ack, out_valid, inv_pin, cap, done, aligned, sref;
    logic [7:0] out_a, out_b, coarse, fine, prev_c, tgt, v;
    logic [15:0] edges;
    logic [25:0] hist[4];
    logic ts = 1'b0, single = 1'b0, s_chk = 1'b0, r_mon = 1'b0;
    int err_count = 0, check_count = 0, cyc = 0, last_chg = -1, rstep = 0, rgap = 0;

    always #5 ref_clk = ~ref_clk;

    sdc_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .conv_valid(conv_valid),
        .conv_rise_a(rise_a), .conv_rise_b(rise_b), .conv_fall(fall),
        .trigger_marker_input(trig), .sysref_in(sref), .sysref_phase_aligned(aligned),
        .out_valid(out_valid), .out_sample_a(out_a), .out_sample_b(out_b),
        .clock_invert_delay(inv_pin), .coarse_aperture_delay(coarse),
        .fine_aperture_delay(fine), .sysref_capture(cap), .sysref_cal_done(done));
    sdc_clkgen_model i_ref (.ref_clk(ref_clk), .rst_n(rst_n), .periodic(periodic),
        .fire(fire), .coarse(coarse), .sysref_in(sref), .sysref_phase_aligned(aligned),
        .edge_cnt(edges));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] exp_smp(logic [7:0] d, logic t);
        return ts ? {d[7:1], t} : d;
    endfunction
    function automatic logic [7:0] step_to(logic [7:0] p, logic [7:0] t, int s);
        if (t > p)
            return (int'(t - p) > s) ? p + 8'(s) : t;
        return (int'(p - t) > s) ? p - 8'(s) : t;
    endfunction
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Classic single cycle; request held until ack is sampled
    task automatic wb(logic we, logic [7:0] adr, logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= d;
        @(posedge ref_clk);
        while (wb_ack !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 50)
            err_count++;
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wait_c();
        for (int n = 0; n < 2000 && coarse !== tgt; n++)
            @(posedge ref_clk);
        chk(coarse, tgt);
    endtask

    // Random converter traffic and an unsynchronised trigger
    always @(posedge ref_clk)
        if (rst_n)
            {rise_a, rise_b, fall, trig, conv_valid} <= 26'(rnd());

    always @(posedge ref_clk)
    begin
        hist[3] = hist[2];
        hist[2] = hist[1];
        hist[1] = hist[0];
        hist[0] = {rise_a, rise_b, fall, trig, conv_valid};
        if (s_chk)
        begin
            chk(out_valid, hist[3][0]);
            chk(out_a, exp_smp(hist[3][25:18], hist[3][1]));
            chk(out_b, exp_smp(single ? hist[3][9:2] : hist[3][17:10], hist[3][1]));
        end
        cyc++;
        // Each move lands toward the target; spacing only between ramp steps
        if (r_mon && coarse !== prev_c)
        begin
            chk(coarse, step_to(prev_c, tgt, rstep));
            if (last_chg >= 0 && rgap > 0)
                chk(cyc - last_chg, rgap);
            last_chg = cyc;
        end
        prev_c = coarse;
    end

    initial
    begin
        #200000;
        err_count++;
        end_sim();
    end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        wb(1'b1, 8'h14, 32'hffffffff);
        for (int i = 0; i < 6; i++)
        begin
            wb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        // Marker off, marker on, then dual-edge lane
        for (int m = 0; m < 3; m++)
        begin
            ts = (m == 1);
            single = (m == 2);
            wb(1'b1, SDC_OFF_CTRL, 32'({single, 3'h0, ts}));
            repeat (5) @(posedge ref_clk);
            s_chk = 1'b1;
            repeat (60) @(posedge ref_clk);
            s_chk = 1'b0;
        end
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(rnd());
            wb(1'b1, SDC_OFF_FINE, 32'(v));
            wb(1'b1, SDC_OFF_CTRL, 32'(i[0]) << SDC_CTRL_INV);
            repeat (3) @(posedge ref_clk);
            chk(fine, v);
            chk(inv_pin, i[0]);
            chk(coarse, 8'h00);
            wb(1'b0, SDC_OFF_FINE, 32'h0);
            chk(rd, 32'(v));
        end
        tgt = 8'h10;
        rstep = 255;
        r_mon = 1'b1;
        wb(1'b1, SDC_OFF_CTRL, 32'h0);
        wb(1'b1, SDC_OFF_COARSE, 32'(tgt));
        repeat (4) @(posedge ref_clk);
        chk(coarse, tgt);
        wb(1'b1, SDC_OFF_CTRL, 32'h1 << SDC_CTRL_RAMP_EN);
        tgt = 8'h13;
        rstep = 1;
        rgap = SDC_RAMP_SLOW_CYC;
        last_chg = -1;
        wb(1'b1, SDC_OFF_COARSE, 32'(tgt));
        wb(1'b0, SDC_OFF_STATUS, 32'h0);
        chk(rd[SDC_ST_BUSY], 1'b1);
        wait_c();
        wb(1'b0, SDC_OFF_STATUS, 32'h0);
        chk(rd, 32'(tgt));
        // Fast ramp, retargeted once the first step has landed
        wb(1'b1, SDC_OFF_CTRL, 32'h3 << SDC_CTRL_RAMP_EN);
        tgt = 8'h40;
        rstep = 4;
        rgap = SDC_RAMP_FAST_CYC;
        last_chg = -1;
        wb(1'b1, SDC_OFF_COARSE, 32'(tgt));
        for (int n = 0; n < 500 && coarse === 8'h13; n++)
            @(posedge ref_clk);
        chk(coarse, 8'h17);
        tgt = 8'h20;
        wb(1'b1, SDC_OFF_COARSE, 32'(tgt));
        last_chg = -1;
        wait_c();
        repeat (400) @(posedge ref_clk);
        chk(coarse, tgt);
        r_mon = 1'b0;
        wb(1'b1, SDC_OFF_CTRL, 32'h1 << SDC_CTRL_CAL_EN);
        periodic = 1'b1;
        rd = 32'h0;
        for (int n = 0; n < 50 && rd[SDC_ST_CAL_DONE] !== 1'b1; n++)
        begin
            repeat (40) @(posedge ref_clk);
            wb(1'b0, SDC_OFF_STATUS, 32'h0);
        end
        chk(done, 1'b1);
        chk(coarse, 8'h23);
        chk(rd[SDC_ST_SREF_SEEN], 1'b1);
        periodic = 1'b0;
        wb(1'b1, SDC_OFF_CTRL, 32'h0);
        repeat (100) @(posedge ref_clk);
        chk(done, 1'b0);
        wb(1'b0, SDC_OFF_SREF_CNT, 32'h0);
        chk(rd, 32'(edges));
        @(posedge ref_clk);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (20) @(posedge ref_clk);
        wb(1'b0, SDC_OFF_SREF_CNT, 32'h0);
        chk(rd, 32'(edges));
        end_sim();
    end
endmodule // tb
